// file: rtl/rcs_pkg.sv
package rcs_pkg;
	localparam int CLK_NS = 8;
	localparam int TICK_MS = 5;
	localparam int TICK_NS = 5_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int RECL_DEF_MS = 10_000;
	localparam int TW = 19;
	localparam int NOBJ = 5;
	localparam int NGRP = 4;
	localparam logic [TW-1:0] RECL_RST = TW'(RECL_DEF_MS / TICK_MS);
	localparam logic [TW-1:0] LOCK_RST = 19'h0_0000;
	// register byte offsets
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_STAT = 12'h004;
	localparam logic [11:0] A_TIMER = 12'h008;
	localparam logic [11:0] A_CMD = 12'h00C;
	localparam logic [11:0] A_GRP_BASE = 12'h020;
	localparam logic [11:0] A_GRP_STRIDE = 12'h010;
	localparam logic [3:0] A_GRP_CFG = 4'h0;
	localparam logic [3:0] A_GRP_LOCK = 4'h4;
	localparam logic [3:0] A_GRP_RECL = 4'h8;
	// field positions
	localparam int CTRL_FEN = 0;
	localparam int CTRL_EXS = 1;
	localparam int CMD_RST = 0;
	localparam int CFG_TGT = 0;
	localparam int CFG_GEN = 3;
	localparam int CFG_CLR = 4;
	localparam int CFG_GRC = 5;
	localparam int TMR_KIND = 24;
	localparam logic [2:0] TGT_RST = 3'h0;
	typedef enum logic [1:0] {ST_READY, ST_LOCKDLY, ST_LOCKED} rcs_state_e;
	typedef enum logic [2:0] {K_NONE, K_LOCKOUT, K_RECLAIM, K_START,
		K_DEAD, K_DISCR, K_SHOTRECL} rcs_kind_e;
	typedef struct packed {
		logic [2:0] tgt;
		logic grpEn;
		logic closeClr;
		logic genRecl;
		logic [TW-1:0] lockT;
		logic [TW-1:0] reclT;
	} rcs_grp_s;
	localparam rcs_grp_s GRP_RST = '{TGT_RST, 1'b0, 1'b0, 1'b0,
		LOCK_RST, RECL_RST};
endpackage

// file: rtl/rcs_timer.sv
module rcs_timer #(
	parameter int W = 19
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// control
	input wire logic tick,
	input wire logic start,
	input wire logic stop,
	input wire logic [W-1:0] load,
	// state
	output logic [W-1:0] remain,
	output logic running,
	output logic expire
);
	logic [W-1:0] remNext;
	logic runNext;
	logic expNext;

	always_comb begin
		remNext = remain;
		runNext = running;
		expNext = 1'b0;
		if (stop) begin
			remNext = '0;
			runNext = 1'b0;
		end else if (start) begin
			remNext = load;
			runNext = (load != '0);
			expNext = (load == '0);
		end else if (running && tick) begin
			if (remain <= W'(1)) begin
				remNext = '0;
				runNext = 1'b0;
				expNext = 1'b1;
			end else begin
				remNext = remain - W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			remain <= '0;
			running <= 1'b0;
			expire <= 1'b0;
		end else begin
			remain <= remNext;
			running <= runNext;
			expire <= expNext;
		end
	end
endmodule

// file: rtl/rcs_supervisor.sv
module rcs_supervisor #(
	parameter int TICK_CYCLES = rcs_pkg::TICK_CYC,
	parameter int NGRP = rcs_pkg::NGRP
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from the field
	input wire logic [4:0] protReq,
	input wire logic extEnableInput,
	input wire logic [$clog2(NGRP)-1:0] activeGroup,
	input wire logic [4:0] objClosed,
	input wire logic [4:0] objStatusOk,
	input wire logic [4:0] closeCmdIn,
	// shot sequencer, same clock
	input wire logic seqRunning,
	input wire logic [4:0] seqShot,
	input wire rcs_pkg::rcs_kind_e seqKind,
	input wire logic [rcs_pkg::TW-1:0] seqRemain,
	input wire logic seqSuccess,
	input wire logic seqFinalTrip,
	input wire logic objError,
	// outputs
	output logic [4:0] openCmd,
	output logic readyIndication,
	output logic lockedIndication
);
	localparam int GW = $clog2(NGRP);
	localparam int TW = rcs_pkg::TW;
	localparam int SW = 21 + GW;

	// two-flop synchroniser for every pin input
	logic [SW-1:0] syncA_reg, syncB_reg, pinPrev_reg;
	logic [4:0] reqS, closedS, okS, closeS, reqPrev, closePrev;
	logic extEnS;
	logic [GW-1:0] grpS;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
			pinPrev_reg <= '0;
		end else begin
			syncA_reg <= {protReq, extEnableInput, activeGroup, objClosed,
				objStatusOk, closeCmdIn};
			syncB_reg <= syncA_reg;
			pinPrev_reg <= syncB_reg;
		end
	end
	assign {reqS, extEnS, grpS, closedS, okS, closeS} = syncB_reg;
	assign reqPrev = pinPrev_reg[SW-1 -: 5];
	assign closePrev = pinPrev_reg[4:0];

	// 5 ms tick from a cycle divider
	logic [31:0] divCnt_reg, divCnt_next;
	logic tick_reg, tick_next;

	always_comb begin
		tick_next = (divCnt_reg == 32'(TICK_CYCLES - 1));
		divCnt_next = tick_next ? 32'h0000_0000 : divCnt_reg + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			divCnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else begin
			divCnt_reg <= divCnt_next;
			tick_reg <= tick_next;
		end
	end

	// settings: global control and one record per group
	logic fen_reg, fen_next, exSel_reg, exSel_next;
	rcs_pkg::rcs_grp_s grp_reg [NGRP];
	rcs_pkg::rcs_grp_s grp_next [NGRP];
	rcs_pkg::rcs_grp_s act;

	// apb decode
	logic [11:0] grpOff;
	logic [GW-1:0] grpIdx;
	logic inGrp, mapped, setup, doWrite, userRst;
	logic [31:0] rdMux, statWord, timerWord;

	assign grpOff = paddr - rcs_pkg::A_GRP_BASE;
	assign grpIdx = grpOff[4 +: GW];
	assign inGrp = (paddr >= rcs_pkg::A_GRP_BASE)
		&& (grpOff < 12'(NGRP * 16))
		&& (grpOff[3:0] == rcs_pkg::A_GRP_CFG
		|| grpOff[3:0] == rcs_pkg::A_GRP_LOCK
		|| grpOff[3:0] == rcs_pkg::A_GRP_RECL);
	assign mapped = inGrp || paddr == rcs_pkg::A_CTRL
		|| paddr == rcs_pkg::A_STAT || paddr == rcs_pkg::A_TIMER
		|| paddr == rcs_pkg::A_CMD;
	assign setup = psel && !penable;
	assign doWrite = psel && penable && pready && pwrite && mapped;
	assign userRst = doWrite && paddr == rcs_pkg::A_CMD
		&& pwdata[rcs_pkg::CMD_RST];

	// active group drives everything live
	assign act = grp_reg[grpS];

	always_comb begin
		fen_next = fen_reg;
		exSel_next = exSel_reg;
		for (int g = 0; g < NGRP; g++) begin
			grp_next[g] = grp_reg[g];
		end
		if (doWrite && paddr == rcs_pkg::A_CTRL) begin
			fen_next = pwdata[rcs_pkg::CTRL_FEN];
			exSel_next = pwdata[rcs_pkg::CTRL_EXS];
		end
		if (doWrite && inGrp) begin
			case (grpOff[3:0])
				rcs_pkg::A_GRP_CFG: begin
					// out-of-range target reads back as the first object
					grp_next[grpIdx].tgt = (pwdata[2:0] > 3'h4) ? 3'h0
						: pwdata[2:0];
					grp_next[grpIdx].grpEn = pwdata[rcs_pkg::CFG_GEN];
					grp_next[grpIdx].closeClr = pwdata[rcs_pkg::CFG_CLR];
					grp_next[grpIdx].genRecl = pwdata[rcs_pkg::CFG_GRC];
				end
				rcs_pkg::A_GRP_LOCK: grp_next[grpIdx].lockT = pwdata[TW-1:0];
				rcs_pkg::A_GRP_RECL: grp_next[grpIdx].reclT = pwdata[TW-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fen_reg <= 1'b0;
			exSel_reg <= 1'b0;
			for (int g = 0; g < NGRP; g++) begin
				grp_reg[g] <= rcs_pkg::GRP_RST;
			end
		end else begin
			fen_reg <= fen_next;
			exSel_reg <= exSel_next;
			for (int g = 0; g < NGRP; g++) begin
				grp_reg[g] <= grp_next[g];
			end
		end
	end

	// supervisor
	rcs_pkg::rcs_state_e state_reg, state_next;
	logic [4:0] tgtHot, openCmd_next;
	logic inUse, newReq, manClose, inhibit, lockStart, lockStop;
	logic reclStart, stopAll, lockRun, lockExp, reclRun;
	logic [TW-1:0] lockRem, reclRem;
	logic ready_next, locked_next;

	assign tgtHot = 5'h01 << act.tgt;
	assign inUse = fen_reg && act.grpEn
		&& (!exSel_reg || extEnS);
	assign newReq = |(reqS & ~reqPrev);
	assign manClose = |(closeS & ~closePrev & tgtHot);
	// every inhibit cause but the state is a live term, so ready comes back on its own in ST_READY
	assign inhibit = !inUse || !(|(okS & tgtHot)) || reclRun
		|| state_reg != rcs_pkg::ST_READY;

	always_comb begin
		state_next = state_reg;
		openCmd_next = 5'h00;
		lockStart = 1'b0;
		reclStart = 1'b0;
		stopAll = 1'b0;
		if (!fen_reg) begin
			stopAll = 1'b1;
			state_next = rcs_pkg::ST_READY;
		end else begin
			if (manClose) begin
				reclStart = 1'b1;
			end
			case (state_reg)
				rcs_pkg::ST_READY: begin
					if (seqSuccess) begin
						reclStart = reclStart || act.genRecl;
						if (act.lockT != '0) begin
							lockStart = 1'b1;
							state_next = rcs_pkg::ST_LOCKDLY;
						end
					end
				end
				rcs_pkg::ST_LOCKDLY: begin
					if (newReq) begin
						openCmd_next = tgtHot;
						state_next = rcs_pkg::ST_LOCKED;
					end else if (lockExp) begin
						state_next = rcs_pkg::ST_READY;
					end
				end
				rcs_pkg::ST_LOCKED: begin
					if (userRst || (act.closeClr && manClose)) begin
						state_next = rcs_pkg::ST_READY;
					end
				end
				default: state_next = rcs_pkg::ST_READY;
			endcase
			if (newReq && reclRun) begin
				state_next = rcs_pkg::ST_LOCKED;
			end
			// lock events beat a reset arriving in the same cycle
			if (seqFinalTrip || objError) begin
				state_next = rcs_pkg::ST_LOCKED;
			end
		end
		// held stopped outside the delay, so a start beaten by a lock dies
		lockStop = stopAll || state_next != rcs_pkg::ST_LOCKDLY;
		ready_next = fen_reg && !inhibit && !reclStart
			&& state_next == rcs_pkg::ST_READY;
		locked_next = state_next == rcs_pkg::ST_LOCKED;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg <= rcs_pkg::ST_READY;
			openCmd <= 5'h00;
			readyIndication <= 1'b0;
			lockedIndication <= 1'b0;
		end else begin
			state_reg <= state_next;
			openCmd <= openCmd_next;
			readyIndication <= ready_next;
			lockedIndication <= locked_next;
		end
	end

	rcs_timer #(.W(TW)) uLock (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tick(tick_reg),
		.start(lockStart),
		.stop(lockStop),
		.load(act.lockT),
		.remain(lockRem),
		.running(lockRun),
		.expire(lockExp)
	);

	rcs_timer #(.W(TW)) uRecl (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.tick(tick_reg),
		.start(reclStart),
		.stop(stopAll),
		.load(act.reclT),
		.remain(reclRem),
		.running(reclRun),
		.expire()
	);

	// status and countdown words
	always_comb begin
		statWord = 32'h0000_0000;
		statWord[0] = inhibit;
		statWord[1] = readyIndication;
		statWord[2] = lockedIndication;
		statWord[3] = seqRunning;
		statWord[4] = !seqRunning;
		statWord[5] = lockRun;
		statWord[6] = reclRun;
		statWord[7] = seqKind == rcs_pkg::K_START;
		statWord[8] = seqKind == rcs_pkg::K_DISCR;
		statWord[13:9] = reqS;
		statWord[18:14] = seqShot;
		timerWord = 32'h0000_0000;
		if (lockRun) begin
			timerWord[TW-1:0] = lockRem;
			timerWord[rcs_pkg::TMR_KIND +: 3] = rcs_pkg::K_LOCKOUT;
		end else if (reclRun) begin
			timerWord[TW-1:0] = reclRem;
			timerWord[rcs_pkg::TMR_KIND +: 3] = rcs_pkg::K_RECLAIM;
		end else if (seqRunning) begin
			timerWord[TW-1:0] = seqRemain;
			timerWord[rcs_pkg::TMR_KIND +: 3] = seqKind;
		end
		rdMux = 32'h0000_0000;
		if (inGrp) begin
			case (grpOff[3:0])
				rcs_pkg::A_GRP_CFG: rdMux[5:0] = {grp_reg[grpIdx].genRecl,
					grp_reg[grpIdx].closeClr, grp_reg[grpIdx].grpEn,
					grp_reg[grpIdx].tgt};
				rcs_pkg::A_GRP_LOCK: rdMux[TW-1:0] = grp_reg[grpIdx].lockT;
				rcs_pkg::A_GRP_RECL: rdMux[TW-1:0] = grp_reg[grpIdx].reclT;
				default: ;
			endcase
		end else if (paddr == rcs_pkg::A_CTRL) begin
			rdMux[1:0] = {exSel_reg, fen_reg};
		end else if (paddr == rcs_pkg::A_STAT) begin
			rdMux = statWord;
		end else if (paddr == rcs_pkg::A_TIMER) begin
			rdMux = timerWord;
		end
	end

	// answer is ready in the first access cycle, no wait states
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				prdata <= rdMux;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_disabled_idle: assert property (!fen_reg |=>
		openCmd == 5'h00 && !readyIndication && !lockedIndication)
		else $error("activity while function disabled");
	a_ext_gate: assert property (fen_reg && exSel_reg && !extEnS
		|=> !readyIndication)
		else $error("ready without external enable");
	a_zero_lockout: assert property (fen_reg && seqSuccess
		&& act.lockT == '0 && state_reg == rcs_pkg::ST_READY
		&& !newReq && !seqFinalTrip && !objError
		|=> state_reg == rcs_pkg::ST_READY)
		else $error("zero lock-out did not stay ready");
	a_lockdly_open: assert property (fen_reg
		&& state_reg == rcs_pkg::ST_LOCKDLY && newReq
		|=> openCmd == $past(tgtHot) && lockedIndication)
		else $error("request in lock-out delay not locked");
	a_reclaim_lock: assert property (fen_reg && reclRun && newReq
		|=> state_reg == rcs_pkg::ST_LOCKED && lockedIndication)
		else $error("request during reclaim not locked");
	a_final_lock: assert property (fen_reg && seqFinalTrip
		|=> lockedIndication && state_reg == rcs_pkg::ST_LOCKED)
		else $error("final trip did not lock");
	a_user_reset: assert property (fen_reg
		&& state_reg == rcs_pkg::ST_LOCKED && userRst && !seqFinalTrip
		&& !objError && !(newReq && reclRun)
		|=> state_reg == rcs_pkg::ST_READY)
		else $error("user reset did not clear lock");
	a_ready_lock: assert property (readyIndication |->
		!lockedIndication && !lockRun && !reclRun)
		else $error("ready together with lock or timer");
	a_close_reclaim: assert property (fen_reg && manClose
		&& act.reclT != '0 |=> reclRun)
		else $error("manual close did not start reclaim");
	a_tick_gap: assert property (tick_reg |=> !tick_reg)
		else $error("tick longer than one cycle");

	c_lockdly: cover property (state_reg == rcs_pkg::ST_LOCKDLY ##1
		state_reg == rcs_pkg::ST_READY);
	c_locked: cover property (lockedIndication ##1 userRst);
	c_reclaim: cover property (reclRun && newReq);
	c_ready: cover property (!readyIndication ##1 readyIndication);
endmodule

// file: bench/rcs_breaker_model.sv
module rcs_breaker_model (
	// clock
	input wire logic clk_sys,
	// commands reaching the breakers
	input wire logic [4:0] openCmd,
	input wire logic [4:0] closeCmdIn,
	input wire logic [4:0] blockObj,
	// breaker status
	output logic [4:0] objClosed,
	output logic [4:0] objStatusOk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] closePrev;
	initial begin
		objClosed = 5'h1F;
		closePrev = 5'h00;
	end
	// an open pulse opens at once, a close edge closes at once
	always @(posedge clk_sys) begin
		closePrev <= closeCmdIn;
		objClosed <= (objClosed & ~openCmd) | (closeCmdIn & ~closePrev);
	end
	// a blocked breaker reports an unknown status
	assign objStatusOk = ~blockObj;
endmodule

// file: bench/rcs_supervisor_test.sv
module rcs_supervisor_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] G0C = rcs_pkg::A_GRP_BASE;
	localparam logic [11:0] G0L = G0C + {8'h00, rcs_pkg::A_GRP_LOCK};
	localparam logic [11:0] G0R = G0C + {8'h00, rcs_pkg::A_GRP_RECL};
	localparam logic [11:0] G1C = G0C + rcs_pkg::A_GRP_STRIDE;
	localparam logic [11:0] ST = rcs_pkg::A_STAT;
	localparam logic [11:0] TM = rcs_pkg::A_TIMER;
	logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0] protReq, closeCmdIn, blockObj, objClosed, objStatusOk;
	logic [4:0] openCmd, seqShot, o;
	logic [1:0] activeGroup;
	logic extEnableInput, seqRunning, seqSuccess, seqFinalTrip, objError;
	logic readyIndication, lockedIndication;
	logic [rcs_pkg::TW-1:0] seqRemain;
	rcs_pkg::rcs_kind_e seqKind;
	int n_fail = 0;
	int compares = 0;
	int n;

	rcs_supervisor #(.TICK_CYCLES(10), .NGRP(4)) u_rcs_supervisor (
		.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.protReq(protReq), .extEnableInput(extEnableInput),
		.activeGroup(activeGroup), .objClosed(objClosed),
		.objStatusOk(objStatusOk), .closeCmdIn(closeCmdIn),
		.seqRunning(seqRunning), .seqShot(seqShot), .seqKind(seqKind),
		.seqRemain(seqRemain), .seqSuccess(seqSuccess),
		.seqFinalTrip(seqFinalTrip), .objError(objError),
		.openCmd(openCmd), .readyIndication(readyIndication),
		.lockedIndication(lockedIndication));

	rcs_breaker_model u_rcs_breaker_model (.clk_sys(clk_sys),
		.openCmd(openCmd), .closeCmdIn(closeCmdIn), .blockObj(blockObj),
		.objClosed(objClosed), .objStatusOk(objStatusOk));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish;
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// the request is held until pready is seen; one idle cycle follows
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		apb(a, 1'b0, 32'h0000_0000, r);
		chk(r & m, e);
	endtask

	// pins pass two sync stages before the state reacts
	task automatic ind(input logic [1:0] e);
		repeat (6) @(posedge clk_sys);
		chk({lockedIndication, readyIndication}, e);
	endtask

	task automatic pulse(input int k);
		if (k == 0) seqSuccess <= 1'b1;
		else if (k == 1) seqFinalTrip <= 1'b1;
		else objError <= 1'b1;
		@(posedge clk_sys);
		seqSuccess <= 1'b0;
		seqFinalTrip <= 1'b0;
		objError <= 1'b0;
		@(posedge clk_sys);
	endtask

	// raise a request and gather every open pulse it causes
	task automatic request();
		o = 5'h00;
		n = 0;
		protReq <= 5'h01;
		repeat (8) begin
			@(posedge clk_sys);
			o = o | openCmd;
			if (openCmd != 5'h00) n++;
		end
		protReq <= 5'h00;
		@(posedge clk_sys);
	endtask

	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		{rstn, psel, penable, pwrite, extEnableInput, seqRunning} = 6'h00;
		{seqSuccess, seqFinalTrip, objError} = 3'h0;
		{protReq, closeCmdIn, blockObj, seqShot} = 20'h0_0000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		activeGroup = 2'h0;
		seqRemain = 19'h0_0000;
		seqKind = rcs_pkg::K_NONE;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(rcs_pkg::A_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(G0C, 32'h0000_003F, 32'h0000_0000);
		rd(G0L, 32'h0007_FFFF, 32'h0000_0000);
		rd(G0R, 32'h0007_FFFF, 32'h0000_07D0);
		rd(12'h3F0, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(err, 1'b1);
		wr(G0C, 32'h0000_000A);
		ind(2'b00);
		wr(rcs_pkg::A_CTRL, 32'h0000_0001);
		ind(2'b01);
		rd(ST, 32'h0000_0027, 32'h0000_0002);
		wr(rcs_pkg::A_CTRL, 32'h0000_0003);
		ind(2'b00);
		extEnableInput <= 1'b1;
		ind(2'b01);
		activeGroup <= 2'h1;
		ind(2'b00);
		activeGroup <= 2'h0;
		ind(2'b01);
		blockObj <= 5'h04;
		ind(2'b00);
		blockObj <= 5'h00;
		ind(2'b01);
		seqRunning <= 1'b1;
		seqShot <= 5'h02;
		seqKind <= rcs_pkg::K_DEAD;
		seqRemain <= 19'h0_0007;
		@(posedge clk_sys);
		rd(ST, 32'h0007_C008, 32'h0000_8008);
		rd(TM, 32'h0707_FFFF, 32'h0400_0007);
		seqRunning <= 1'b0;
		seqKind <= rcs_pkg::K_NONE;
		// lock-out after success, hit by a new request
		wr(G0L, 32'h0000_0003);
		pulse(0);
		rd(TM, 32'h0700_0000, 32'h0100_0000);
		rd(ST, 32'h0000_0020, 32'h0000_0020);
		request();
		chk(o, 5'h04);
		chk(n, 1);
		ind(2'b10);
		wr(rcs_pkg::A_CMD, 32'h0000_0001);
		ind(2'b01);
		wr(G0L, 32'h0000_0002);
		pulse(0);
		repeat (40) @(posedge clk_sys);
		ind(2'b01);
		wr(G0L, 32'h0000_0000);
		pulse(0);
		ind(2'b01);
		request();
		ind(2'b01);
		// close reclaim, then lock cleared by a close command
		wr(G0R, 32'h0000_0004);
		closeCmdIn <= 5'h04;
		ind(2'b00);
		rd(TM, 32'h0700_0000, 32'h0200_0000);
		request();
		ind(2'b10);
		wr(G0C, 32'h0000_001A);
		closeCmdIn <= 5'h00;
		ind(2'b10);
		closeCmdIn <= 5'h04;
		ind(2'b00);
		repeat (60) @(posedge clk_sys);
		ind(2'b01);
		pulse(1);
		ind(2'b10);
		wr(rcs_pkg::A_CMD, 32'h0000_0001);
		ind(2'b01);
		pulse(2);
		ind(2'b10);
		wr(rcs_pkg::A_CMD, 32'h0000_0001);
		ind(2'b01);
		// success with general reclaim as well
		wr(G0C, 32'h0000_002A);
		pulse(0);
		rd(TM, 32'h0700_0000, 32'h0200_0000);
		request();
		ind(2'b10);
		wr(rcs_pkg::A_CTRL, 32'h0000_0000);
		ind(2'b00);
		tally_and_finish();
	end
endmodule
